//--- src/regulator_control_registers.sv
// Register bank driving the regulator analog controls.
// Assumes a same-clock serial engine gives single-cycle write/read
// strobes; enable pin and overcurrent come from pins.
`timescale 1ns/1ps
module regulator_control_registers #(
    parameter bit FINE_VARIANT = 1'b0,
    parameter bit HAS_BLEED = 1'b1,
    parameter logic [7:0] LEVEL_DEFAULT = 8'h78,
    parameter bit HOLD_DEFAULT = 1'b0,
    parameter int HICCUP_WAIT = regulator_control_pkg::HICCUP_CYCLES
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    input wire logic enable_pin_i,
    input wire logic overcurrent_i,
    input wire logic wr_strobe_i,
    input wire logic rd_strobe_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o,
    output logic [7:0] ramp_code_o,
    output logic converter_run_o,
    output logic serial_awake_o,
    output logic bleed_on_o,
    output logic [1:0] mode_o,
    output logic amp_steady_o,
    output logic current_limit_o,
    output logic aux_switch_o
);
    localparam logic [7:0] CODE_MAX = FINE_VARIANT ?
        regulator_control_pkg::FINE_MAX : regulator_control_pkg::WIDE_MAX;
    localparam logic [7:0] CFG_RST = FINE_VARIANT ?
        regulator_control_pkg::FINE_CFG_RST :
        regulator_control_pkg::WIDE_CFG_RST;

    logic [1:0] pin_sync_reg;
    logic [1:0] oc_sync_reg;
    logic pin_prev_reg;
    logic loaded_reg;
    logic [7:0] level_reg;
    logic [7:0] config_reg;
    logic [7:0] response_reg;
    logic under_flag_reg;
    logic over_flag_reg;
    logic oc_flag_reg;
    logic [7:0] ramp_reg;
    logic [15:0] ramp_cnt_reg;
    logic [31:0] hiccup_cnt_reg;
    regulator_control_pkg::oc_state_t oc_reg;
    logic pin_hi;
    logic oc_hi;
    logic part_on;
    logic run;
    logic [7:0] clamped;
    logic [15:0] ramp_period;
    logic wr_level;
    logic wr_config;
    logic wr_response;
    logic rd_flags;

    assign pin_hi = pin_sync_reg[1];
    assign oc_hi = oc_sync_reg[1];
    assign wr_level = wr_strobe_i &&
        addr_i == regulator_control_pkg::ADDR_LEVEL;
    assign wr_config = wr_strobe_i &&
        addr_i == regulator_control_pkg::ADDR_CONFIG;
    assign wr_response = wr_strobe_i &&
        addr_i == regulator_control_pkg::ADDR_RESPONSE;
    assign rd_flags = rd_strobe_i &&
        addr_i == regulator_control_pkg::ADDR_FLAGS;
    // Part on from pin or hold override
    assign part_on = pin_hi ||
        response_reg[regulator_control_pkg::RSP_HOLD];
    // Run bit gated with part on (pin or hold) and overcurrent state
    assign run = part_on && config_reg[regulator_control_pkg::CFG_RUN] &&
        oc_reg == regulator_control_pkg::OC_RUN;

    // Clamp written code into the window
    always_comb begin
        if (wdata_i < regulator_control_pkg::CODE_MIN) begin
            clamped = regulator_control_pkg::CODE_MIN;
        end else if (wdata_i > CODE_MAX) begin
            clamped = CODE_MAX;
        end else begin
            clamped = wdata_i;
        end
    end

    // Slew: rate 0 base, 1 twice as fast, 2 quarter, 3 half
    always_comb begin
        unique case (config_reg[5:4])
            2'h0: ramp_period = 16'(regulator_control_pkg::BASE_CYCLES);
            2'h1: ramp_period = 16'(regulator_control_pkg::BASE_CYCLES / 2);
            2'h2: ramp_period = 16'(regulator_control_pkg::BASE_CYCLES * 4);
            2'h3: ramp_period = 16'(regulator_control_pkg::BASE_CYCLES * 2);
        endcase
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pin_sync_reg <= 2'h0;
            oc_sync_reg <= 2'h0;
            pin_prev_reg <= 1'b0;
        end else if (clk_en_i) begin
            pin_sync_reg <= {pin_sync_reg[0], enable_pin_i};
            oc_sync_reg <= {oc_sync_reg[0], overcurrent_i};
            pin_prev_reg <= pin_hi;
        end
    end

    // Output level code register, default loaded after reset
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            level_reg <= 8'h00;
            loaded_reg <= 1'b0;
        end else if (clk_en_i) begin
            if (!loaded_reg) begin
                level_reg <= LEVEL_DEFAULT;
                loaded_reg <= 1'b1;
            end else if (wr_level && part_on) begin
                level_reg <= clamped;
            end
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            config_reg <= 8'h00;
            response_reg <= 8'h00;
        end else if (clk_en_i) begin
            if (!loaded_reg) begin
                config_reg <= CFG_RST;
                response_reg <= {3'h0, HOLD_DEFAULT, 4'h0};
            end else begin
                if (wr_config && part_on) begin
                    config_reg <= {wdata_i[7], HAS_BLEED & wdata_i[6],
                        wdata_i[5:4], wdata_i[3:0]};
                end
                if (wr_response && part_on) begin
                    // Aux bit reserved in the fine variant
                    response_reg <= {wdata_i[7:6],
                        ~FINE_VARIANT & wdata_i[5], wdata_i[4],
                        4'h0};
                end
            end
        end
    end

    // Range flags; set wins over read clear
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            under_flag_reg <= 1'b0;
            over_flag_reg <= 1'b0;
            oc_flag_reg <= 1'b0;
        end else if (clk_en_i) begin
            if (wr_level && part_on && loaded_reg &&
                wdata_i < regulator_control_pkg::CODE_MIN) begin
                under_flag_reg <= 1'b1;
            end else if (rd_flags) begin
                under_flag_reg <= 1'b0;
            end
            if (wr_level && part_on && loaded_reg && wdata_i > CODE_MAX) begin
                over_flag_reg <= 1'b1;
            end else if (rd_flags) begin
                over_flag_reg <= 1'b0;
            end
            if (oc_hi && run) begin
                oc_flag_reg <= 1'b1;
            end else if (rd_flags) begin
                oc_flag_reg <= 1'b0;
            end
        end
    end

    // Ramp tracking toward level code
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ramp_reg <= 8'h00;
            ramp_cnt_reg <= 16'h0000;
        end else if (clk_en_i) begin
            if (!loaded_reg) begin
                ramp_reg <= LEVEL_DEFAULT;
            end else if (ramp_reg == level_reg) begin
                ramp_cnt_reg <= 16'h0000;
            end else if (ramp_cnt_reg >= ramp_period - 16'h0001) begin
                ramp_cnt_reg <= 16'h0000;
                ramp_reg <= (ramp_reg < level_reg) ? ramp_reg + 8'h01 :
                    ramp_reg - 8'h01;
            end else begin
                ramp_cnt_reg <= ramp_cnt_reg + 16'h0001;
            end
        end
    end

    // Overcurrent response
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            oc_reg <= regulator_control_pkg::OC_RUN;
            hiccup_cnt_reg <= 32'h0;
        end else if (clk_en_i) begin
            unique case (oc_reg)
                regulator_control_pkg::OC_RUN: begin
                    if (oc_hi && part_on &&
                        config_reg[regulator_control_pkg::CFG_RUN]) begin
                        if (response_reg[7:6] ==
                            regulator_control_pkg::OC_HICCUP) begin
                            oc_reg <= regulator_control_pkg::OC_WAIT;
                            hiccup_cnt_reg <= 32'h0;
                        end else if (response_reg[7:6] ==
                            regulator_control_pkg::OC_SHUTDOWN) begin
                            oc_reg <= regulator_control_pkg::OC_OFF;
                        end
                    end
                end
                regulator_control_pkg::OC_WAIT: begin
                    if (hiccup_cnt_reg >= 32'(HICCUP_WAIT - 1)) begin
                        oc_reg <= regulator_control_pkg::OC_RUN;
                    end else begin
                        hiccup_cnt_reg <= hiccup_cnt_reg + 32'h1;
                    end
                end
                regulator_control_pkg::OC_OFF: begin
                    if ((wr_config && part_on) ||
                        (pin_hi && !pin_prev_reg)) begin
                        oc_reg <= regulator_control_pkg::OC_RUN;
                    end
                end
            endcase
        end
    end

    // Registered outputs
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_o <= 8'h00;
            ramp_code_o <= 8'h00;
            converter_run_o <= 1'b0;
            serial_awake_o <= 1'b0;
            bleed_on_o <= 1'b0;
            mode_o <= 2'h0;
            amp_steady_o <= 1'b0;
            current_limit_o <= 1'b0;
            aux_switch_o <= 1'b0;
        end else if (clk_en_i) begin
            unique case (addr_i)
                regulator_control_pkg::ADDR_FLAGS: rdata_o <= {4'h0,
                    under_flag_reg, over_flag_reg, 1'b0, oc_flag_reg};
                regulator_control_pkg::ADDR_LEVEL: rdata_o <= level_reg;
                regulator_control_pkg::ADDR_CONFIG: rdata_o <= config_reg;
                regulator_control_pkg::ADDR_RESPONSE: rdata_o <= response_reg;
                default: rdata_o <= 8'h00;
            endcase
            ramp_code_o <= ramp_reg;
            converter_run_o <= run;
            serial_awake_o <= part_on;
            bleed_on_o <= part_on && !config_reg[7] && config_reg[6] &&
                config_reg[3:2] !=
                regulator_control_pkg::MODE_BYPASS;
            mode_o <= FINE_VARIANT && config_reg[3:2] ==
                regulator_control_pkg::MODE_BYPASS ? 2'h0 :
                config_reg[3:2];
            amp_steady_o <=
                config_reg[regulator_control_pkg::CFG_AMP];
            current_limit_o <= response_reg[7];
            aux_switch_o <=
                response_reg[regulator_control_pkg::RSP_AUX];
        end
    end

    chk_flag_under_set: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        clk_en_i && wr_level && part_on && loaded_reg &&
        wdata_i < regulator_control_pkg::CODE_MIN |=> under_flag_reg)
        else $error("under flag not set");
    chk_flag_over_set: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        clk_en_i && wr_level && part_on && loaded_reg &&
        wdata_i > CODE_MAX |=> over_flag_reg)
        else $error("over flag not set");
    chk_level_in_range: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        loaded_reg |-> level_reg >= regulator_control_pkg::CODE_MIN &&
        level_reg <= CODE_MAX)
        else $error("level out of window");
    chk_run_needs_on: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        converter_run_o && $past(clk_en_i) |-> $past(part_on))
        else $error("run without enable");
    chk_shutdown_holds: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        oc_reg == regulator_control_pkg::OC_OFF && clk_en_i &&
        !wr_config && !(pin_hi && !pin_prev_reg) |=>
        oc_reg == regulator_control_pkg::OC_OFF)
        else $error("shutdown released early");

    // Host clears the run bit while the part is on
    sequence run_bit_cleared;
        clk_en_i && wr_config && part_on &&
            !wdata_i[regulator_control_pkg::CFG_RUN];
    endsequence

    // Bit taken, then one enabled edge to reach the output
    sequence run_drop_taken;
        run_bit_cleared ##1 clk_en_i;
    endsequence

    chk_run_bit_stops: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        run_drop_taken |=> !converter_run_o)
        else $error("run bit clear ignored");

    // Hiccup wait has reached its full count
    sequence hiccup_done;
        clk_en_i && oc_reg == regulator_control_pkg::OC_WAIT &&
            hiccup_cnt_reg >= 32'(HICCUP_WAIT - 1);
    endsequence

    chk_hiccup_restart: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        hiccup_done |=> oc_reg == regulator_control_pkg::OC_RUN)
        else $error("hiccup wait not ended");
endmodule

//--- src/regulator_control_pkg.sv
// Constants for the regulator control register bank.
// Assumes an outside serial engine presents byte writes and reads.
package regulator_control_pkg;
    localparam logic [7:0] ADDR_FLAGS = 8'h03;
    localparam logic [7:0] ADDR_LEVEL = 8'h11;
    localparam logic [7:0] ADDR_CONFIG = 8'h12;
    localparam logic [7:0] ADDR_RESPONSE = 8'h13;
    localparam logic [7:0] CODE_MIN = 8'h04;
    localparam logic [7:0] WIDE_MAX = 8'hD7;
    localparam logic [7:0] FINE_MAX = 8'hEC;
    localparam int WIDE_STEP_UV = 25000;
    localparam int FINE_STEP_UV = 5000;
    localparam int CFG_RUN = 7;
    localparam int CFG_BLEED = 6;
    localparam int CFG_RATE = 4;
    localparam int CFG_MODE = 2;
    localparam int CFG_AMP = 0;
    localparam int RSP_OC = 6;
    localparam int RSP_AUX = 5;
    localparam int RSP_HOLD = 4;
    localparam int FLG_UNDER = 3;
    localparam int FLG_OVER = 2;
    localparam logic [7:0] WIDE_CFG_RST = 8'h81;
    localparam logic [7:0] FINE_CFG_RST = 8'h91;
    localparam logic [1:0] MODE_BYPASS = 2'h3;
    localparam logic [1:0] OC_HICCUP = 2'h0;
    localparam logic [1:0] OC_SHUTDOWN = 2'h1;
    localparam int CLK_MHZ = 40;
    localparam int HICCUP_MS = 100;
    localparam int HICCUP_CYCLES = HICCUP_MS * CLK_MHZ * 1000;
    // Wide ramp at 3.125mV/us: 8 us per 25mV step
    localparam int WIDE_BASE_NS = 8000;
    // Fine ramp at 0.625mV/us: 8 us per 5mV step
    localparam int FINE_BASE_NS = 8000;
    localparam int CLK_PERIOD_NS = 25;
    localparam int BASE_CYCLES = WIDE_BASE_NS / CLK_PERIOD_NS;
    typedef enum logic [2:0] {
        OC_RUN = 3'b001,
        OC_WAIT = 3'b010,
        OC_OFF = 3'b100
    } oc_state_t;
endpackage

//--- test/regulator_host_model.sv
// Host model issuing single-byte register writes and reads.
// Assumes the register bank samples strobes on the rising clock edge.
`timescale 1ns/1ps
module regulator_host_model (
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    output logic wr_strobe_o,
    output logic rd_strobe_o,
    output logic [7:0] addr_o,
    output logic [7:0] wdata_o
);
    initial begin
        wr_strobe_o = 1'b0;
        rd_strobe_o = 1'b0;
        addr_o = 8'h00;
        wdata_o = 8'h00;
    end

    // One-cycle write; callers keep amp type 0 in limit modes
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clk_i);
        addr_o = a;
        wdata_o = v;
        wr_strobe_o = 1'b1;
        @(negedge clk_i);
        wr_strobe_o = 1'b0;
        wdata_o = ~v;
    endtask

    // Data is registered one edge after the address
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(negedge clk_i);
        addr_o = a;
        rd_strobe_o = 1'b1;
        @(negedge clk_i);
        rd_strobe_o = 1'b0;
        v = rdata_i;
    endtask
endmodule

//--- test/tb.sv
// Self-checking bench for the regulator register bank.
// Runs the wide and fine variants with a short hiccup wait.
`timescale 1ns/1ps
module tb;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic enable_pin_i = 1'b1;
    logic overcurrent_i = 1'b0;
    logic wr_strobe, rd_strobe;
    logic [7:0] addr, wdata, rdata_o, ramp_code_o, d;
    logic converter_run_o, serial_awake_o, bleed_on_o;
    logic [1:0] mode_o;
    logic amp_steady_o, current_limit_o, aux_switch_o;
    logic clk_en_i = 1'b1;
    logic [7:0] rdata_fine;
    logic [1:0] mode_fine;
    logic aux_fine;
    logic [1:0] modes [3] = '{2'h0, 2'h2, 2'h3};
    int miscompares = 0;
    int comparisons = 0;

    initial begin
        forever #12.5 clk_i = ~clk_i;
    end

    regulator_host_model host (.clk_i(clk_i), .rdata_i(rdata_o),
        .wr_strobe_o(wr_strobe), .rd_strobe_o(rd_strobe),
        .addr_o(addr), .wdata_o(wdata));

    regulator_control_registers #(.LEVEL_DEFAULT(8'h10),
        .HICCUP_WAIT(50)) dut (.clk_i(clk_i),
        .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
        .enable_pin_i(enable_pin_i), .overcurrent_i(overcurrent_i),
        .wr_strobe_i(wr_strobe), .rd_strobe_i(rd_strobe),
        .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata_o),
        .ramp_code_o(ramp_code_o), .converter_run_o(converter_run_o),
        .serial_awake_o(serial_awake_o), .bleed_on_o(bleed_on_o),
        .mode_o(mode_o), .amp_steady_o(amp_steady_o),
        .current_limit_o(current_limit_o),
        .aux_switch_o(aux_switch_o));

    regulator_control_registers #(.FINE_VARIANT(1'b1),
        .LEVEL_DEFAULT(8'h10), .HICCUP_WAIT(50)) dut_fine (.clk_i(clk_i),
        .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
        .enable_pin_i(enable_pin_i), .overcurrent_i(overcurrent_i),
        .wr_strobe_i(wr_strobe), .rd_strobe_i(rd_strobe),
        .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata_fine),
        .ramp_code_o(), .converter_run_o(), .serial_awake_o(),
        .bleed_on_o(), .mode_o(mode_fine), .amp_steady_o(),
        .current_limit_o(), .aux_switch_o(aux_fine));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic chkb(input logic got, input logic exp);
        chk({7'h00, got}, {7'h00, exp});
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    task automatic wait_code(input logic [7:0] t, input int n);
        for (int i = 0; i < n && ramp_code_o !== t; i++) @(negedge clk_i);
    endtask

    task automatic give_verdict();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        miscompares++;
        give_verdict();
    end

    initial begin
        cyc(20);
        reset_n_i = 1'b1;
        cyc(4);
        host.rd(regulator_control_pkg::ADDR_LEVEL, d);
        chk(d, 8'h10);
        host.rd(regulator_control_pkg::ADDR_CONFIG, d);
        chk(d, regulator_control_pkg::WIDE_CFG_RST);
        chk(rdata_fine, regulator_control_pkg::FINE_CFG_RST);
        host.rd(regulator_control_pkg::ADDR_RESPONSE, d);
        chk(d, 8'h00);
        host.rd(8'h50, d);
        chk(d, 8'h00);
        wait_code(8'h10, 4000);
        chk(ramp_code_o, 8'h10);
        chkb(converter_run_o, 1'b1);
        chkb(amp_steady_o, 1'b1);
        $display("reset test done");
        host.wr(regulator_control_pkg::ADDR_CONFIG, 8'h91);
        host.wr(regulator_control_pkg::ADDR_LEVEL, 8'h13);
        cyc(150);
        chk(ramp_code_o, 8'h10);
        wait_code(8'h13, 400);
        chk(ramp_code_o, 8'h13);
        $display("ramp test done");
        host.wr(regulator_control_pkg::ADDR_LEVEL, 8'hF0);
        host.rd(regulator_control_pkg::ADDR_LEVEL, d);
        chk(d, regulator_control_pkg::WIDE_MAX);
        chk(rdata_fine, regulator_control_pkg::FINE_MAX);
        host.rd(regulator_control_pkg::ADDR_FLAGS, d);
        chk(d & 8'h0C, 8'h04);
        host.rd(regulator_control_pkg::ADDR_FLAGS, d);
        chk(d & 8'h0C, 8'h00);
        host.wr(regulator_control_pkg::ADDR_LEVEL, 8'h02);
        host.rd(regulator_control_pkg::ADDR_LEVEL, d);
        chk(d, regulator_control_pkg::CODE_MIN);
        host.rd(regulator_control_pkg::ADDR_FLAGS, d);
        chk(d & 8'h0C, 8'h08);
        host.wr(regulator_control_pkg::ADDR_LEVEL, 8'hD7);
        host.wr(8'h50, 8'h5A);
        host.rd(8'h50, d);
        chk(d, 8'h00);
        host.rd(regulator_control_pkg::ADDR_FLAGS, d);
        chk(d & 8'h0C, 8'h00);
        $display("range test done");
        host.wr(regulator_control_pkg::ADDR_CONFIG, 8'h40);
        cyc(3);
        chkb(converter_run_o, 1'b0);
        chkb(serial_awake_o, 1'b1);
        chkb(bleed_on_o, 1'b1);
        chkb(amp_steady_o, 1'b0);
        for (int i = 0; i < 3; i++) begin
            host.wr(regulator_control_pkg::ADDR_CONFIG, {4'h4, modes[i], 2'h0});
            cyc(3);
            chk({6'h00, mode_o}, {6'h00, modes[i]});
        end
        chk({6'h00, mode_fine}, 8'h00);
        chkb(bleed_on_o, 1'b0);
        host.wr(regulator_control_pkg::ADDR_CONFIG, 8'h81);
        cyc(3);
        chkb(converter_run_o, 1'b1);
        enable_pin_i = 1'b0;
        cyc(5);
        chkb(converter_run_o, 1'b0);
        chkb(serial_awake_o, 1'b0);
        host.wr(regulator_control_pkg::ADDR_LEVEL, 8'h30);
        enable_pin_i = 1'b1;
        cyc(5);
        host.rd(regulator_control_pkg::ADDR_LEVEL, d);
        chk(d, regulator_control_pkg::WIDE_MAX);
        clk_en_i = 1'b0;
        host.wr(regulator_control_pkg::ADDR_LEVEL, 8'h30);
        clk_en_i = 1'b1;
        host.rd(regulator_control_pkg::ADDR_LEVEL, d);
        chk(d, regulator_control_pkg::WIDE_MAX);
        host.wr(regulator_control_pkg::ADDR_RESPONSE, 8'h30);
        cyc(3);
        chkb(aux_switch_o, 1'b1);
        chkb(aux_fine, 1'b0);
        enable_pin_i = 1'b0;
        cyc(5);
        chkb(converter_run_o, 1'b1);
        chkb(serial_awake_o, 1'b1);
        enable_pin_i = 1'b1;
        $display("enable test done");
        host.wr(regulator_control_pkg::ADDR_RESPONSE, 8'h40);
        overcurrent_i = 1'b1;
        cyc(5);
        chkb(converter_run_o, 1'b0);
        chkb(aux_switch_o, 1'b0);
        chkb(current_limit_o, 1'b0);
        overcurrent_i = 1'b0;
        cyc(60);
        chkb(converter_run_o, 1'b0);
        host.wr(regulator_control_pkg::ADDR_CONFIG, 8'h81);
        cyc(3);
        chkb(converter_run_o, 1'b1);
        host.rd(regulator_control_pkg::ADDR_FLAGS, d);
        chk(d & 8'h01, 8'h01);
        host.wr(regulator_control_pkg::ADDR_RESPONSE, 8'h00);
        overcurrent_i = 1'b1;
        cyc(5);
        chkb(converter_run_o, 1'b0);
        overcurrent_i = 1'b0;
        cyc(80);
        chkb(converter_run_o, 1'b1);
        host.wr(regulator_control_pkg::ADDR_CONFIG, 8'h80);
        host.wr(regulator_control_pkg::ADDR_RESPONSE, 8'h80);
        overcurrent_i = 1'b1;
        cyc(5);
        chkb(current_limit_o, 1'b1);
        chkb(converter_run_o, 1'b1);
        overcurrent_i = 1'b0;
        $display("overcurrent test done");
        give_verdict();
    end
endmodule
